// ---- core/src_regs.svh ----
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH

// Time-out table, indexed by {clock_source_fuse, startup_time_fuse}
`define SRC_FUSE_W        4
`define SRC_TOUT_SHORT_NS 64000
`define SRC_TOUT_LONG_NS  4100000
`define SRC_TOUT_MIN_NS   8
`define SRC_CLK_NS        8
`define SRC_CNT_W         20
// Reset value of the port bank held by the controller
`define SRC_PORT_INIT     8'h00

`endif

// ---- core/src_pkg.sv ----
package src_pkg;
  typedef enum logic [1:0] {
    SRC_HOLD,
    SRC_COUNT,
    SRC_RUN
  } src_state_e;
endpackage

// ---- core/src_system_reset_control.sv ----
// Contract
// - Hold ports at initial value, then fetch vector
// - Ports go to initial state asynchronously, except on watchdog reset
// - Stretch reset by fuse-selected delay count
// - Any of five sources asserts reset
// - Power-on low holds; threshold starts delay
// - Supply drop reasserts reset immediately
// - Long enough low pin pulse resets
// - Pin release waits for full time-out
// - Watchdog reset only when watchdog enabled
// - Brown-out reset only when detector enabled
// - Test-port scan register holds reset
// - Watchdog pulse one cycle, count starts after the pulse
// - Brown-out trips low, releases after time-out
`include "src_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module src_system_reset_control #(
  parameter int unsigned TOUT_SHORT_CYC =
    (`SRC_TOUT_SHORT_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS,
  parameter int unsigned TOUT_LONG_CYC =
    (`SRC_TOUT_LONG_NS + `SRC_CLK_NS - 1) / `SRC_CLK_NS,
  parameter int unsigned PORT_W = 8
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_power_on_below_n,
  input  wire logic                   i_external_reset_pin_n,
  input  wire logic                   i_watchdog_expired,
  input  wire logic                   i_watchdog_enable,
  input  wire logic                   i_brownout_below,
  input  wire logic                   i_brownout_enable,
  input  wire logic                   i_scan_reset_bit,
  input  wire logic [1:0]             i_startup_time_fuse,
  input  wire logic [1:0]             i_clock_source_fuse,
  input  wire logic [PORT_W-1:0]      i_port_data,
  output logic                        o_core_reset,
  output logic                        o_fetch_vector,
  output logic      [PORT_W-1:0]      o_port
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage read only by the second
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] next_sync1;
  logic [4:0] next_sync2;

  always_comb
  begin
    next_sync1 = {~i_power_on_below_n, ~i_external_reset_pin_n,
                  i_watchdog_expired & i_watchdog_enable,
                  i_brownout_below & i_brownout_enable,
                  i_scan_reset_bit};
    next_sync2 = sync1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sync1 <= 5'h1F;
      sync2 <= 5'h1F;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined source level, async path for port forcing. The watchdog stays
  // off this path: a held expiry level must not stretch its one-cycle pulse.
  logic async_any;
  assign async_any = ~i_power_on_below_n
                   | ~i_external_reset_pin_n
                   | (i_brownout_below & i_brownout_enable)
                   | i_scan_reset_bit;

  logic sync_any;
  assign sync_any = |sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog expiry shortened to a single-cycle pulse
  logic wdt_prev;
  logic next_wdt_prev;
  logic wdt_pulse;

  always_comb
  begin
    next_wdt_prev = sync2[2];
    wdt_pulse     = sync2[2] & ~wdt_prev;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      wdt_prev <= 1'b1;
    else
      wdt_prev <= next_wdt_prev;
  end

  logic sources_active;
  assign sources_active = sync2[4] | sync2[3] | sync2[1] | sync2[0]
                        | wdt_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // Delay counter
  logic [`SRC_CNT_W-1:0] tout_cyc;

  always_comb
  begin
    // Long delay for the slow start-up setting or clock source setting 3
    if (i_startup_time_fuse == 2'h3 || i_clock_source_fuse == 2'h3)
      tout_cyc = `SRC_CNT_W'(TOUT_LONG_CYC);
    else
      tout_cyc = `SRC_CNT_W'(TOUT_SHORT_CYC);
  end

  src_pkg::src_state_e   state;
  src_pkg::src_state_e   next_state;
  logic [`SRC_CNT_W-1:0] cnt;
  logic [`SRC_CNT_W-1:0] next_cnt;
  logic                  core_rst;
  logic                  next_core_rst;
  logic                  fetch;
  logic                  next_fetch;

  always_comb
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_core_rst = core_rst;
    next_fetch    = 1'b0;
    case (state)
      src_pkg::SRC_HOLD:
      begin
        next_core_rst = 1'b1;
        if (!sources_active)
        begin
          next_state = src_pkg::SRC_COUNT;
          next_cnt   = '0;
        end
      end
      src_pkg::SRC_COUNT:
      begin
        if (sources_active)
          next_state = src_pkg::SRC_HOLD;
        else if (cnt >= tout_cyc - `SRC_CNT_W'(1))
        begin
          next_state    = src_pkg::SRC_RUN;
          next_core_rst = 1'b0;
          next_fetch    = 1'b1;
        end
        else
          next_cnt = cnt + `SRC_CNT_W'(1);
      end
      src_pkg::SRC_RUN:
      begin
        if (sources_active)
        begin
          next_state    = src_pkg::SRC_HOLD;
          next_core_rst = 1'b1;
        end
      end
      default:
      begin
        next_state    = src_pkg::SRC_HOLD;
        next_core_rst = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state    <= src_pkg::SRC_HOLD;
      cnt      <= '0;
      core_rst <= 1'b1;
      fetch    <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cnt      <= next_cnt;
      core_rst <= next_core_rst;
      fetch    <= next_fetch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs. Reset assertion is asynchronous from the level sources, release
  // waits for the clocked counter; sources are pins so no clock is needed.
  always_ff @(posedge i_clk or posedge async_any)
  begin
    if (async_any)
    begin
      o_core_reset <= 1'b1;
      o_port       <= PORT_W'(`SRC_PORT_INIT);
    end
    else if (i_rst || core_rst)
    begin
      o_core_reset <= 1'b1;
      o_port       <= PORT_W'(`SRC_PORT_INIT);
    end
    else
    begin
      o_core_reset <= 1'b0;
      o_port       <= i_port_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_fetch_vector <= 1'b0;
    else
      o_fetch_vector <= fetch;
  end

endmodule // src_system_reset_control

`default_nettype wire

// ---- tb/src_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module src_source_model (
  output logic o_por_n,
  output logic o_pin_n,
  output logic o_wd,
  output logic o_bo,
  output logic o_scan
);
  // Supply starts below threshold, as at a real power-up
  initial {o_por_n, o_pin_n, o_wd, o_bo, o_scan} = 5'h08;
  task automatic drive(input int s, input logic a);
    case (s)
      0: o_por_n = !a;
      1: o_pin_n = !a;
      2: o_wd = a;
      3: o_bo = a;
      default: o_scan = a;
    endcase
  endtask
endmodule  // src_source_model
`default_nettype wire

// ---- tb/src_reset_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module src_reset_properties #(parameter int unsigned PORT_W = 8) (
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_power_on_below_n,
  input wire logic              i_external_reset_pin_n,
  input wire logic              i_watchdog_expired,
  input wire logic              i_watchdog_enable,
  input wire logic              i_brownout_below,
  input wire logic              i_brownout_enable,
  input wire logic              i_scan_reset_bit,
  input wire logic              o_core_reset,
  input wire logic              o_fetch_vector,
  input wire logic [PORT_W-1:0] o_port
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic wd = i_watchdog_expired && i_watchdog_enable;
  wire logic src = !i_power_on_below_n || !i_external_reset_pin_n ||
    i_scan_reset_bit || (i_brownout_below && i_brownout_enable);
  wire logic q = !o_core_reset && !src && !wd;
  sequence s_drop; $fell(src); endsequence
  sequence s_rel; $fell(o_core_reset); endsequence
  AST_POR: assert property (!i_power_on_below_n |-> o_core_reset)
    else $error("supply low without reset");
  AST_PIN: assert property (!i_external_reset_pin_n |-> o_core_reset)
    else $error("pin low without reset");
  AST_BO: assert property (i_brownout_below && i_brownout_enable
    |-> o_core_reset) else $error("brown-out without reset");
  AST_SCAN: assert property (i_scan_reset_bit |-> o_core_reset)
    else $error("scan bit without reset");
  AST_PORT: assert property (o_core_reset |-> o_port == '0)
    else $error("port not at initial value");
  AST_HOLD: assert property (s_drop |-> o_core_reset [*4])
    else $error("reset not stretched");
  AST_FETCH: assert property (s_rel |-> ##[0:1]
    (o_fetch_vector ##1 !o_fetch_vector)) else $error("fetch pulse");
  AST_WD: assert property ($rose(wd) && !o_core_reset
    |-> ##[1:4] o_core_reset) else $error("watchdog reset missing");
  AST_QUIET: assert property (q [*4] ##1 (!src && !wd)
    |-> !o_core_reset) else $error("reset without enabled source");
endmodule  // src_reset_properties
bind src_system_reset_control src_reset_properties #(.PORT_W(PORT_W))
  src_reset_properties_i (.*);
`default_nettype wire

// ---- tb/src_system_reset_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module src_system_reset_control_tb;
  localparam int TS = 4;
  localparam int TL = 16;
  logic i_clk = 0, i_rst = 1, i_watchdog_enable = 1, i_brownout_enable = 1;
  logic i_power_on_below_n, i_external_reset_pin_n, i_watchdog_expired;
  logic i_brownout_below, i_scan_reset_bit, o_core_reset, o_fetch_vector;
  logic [1:0] i_startup_time_fuse = 2'h0, i_clock_source_fuse = 2'h0;
  logic [7:0] i_port_data = 8'hA5, o_port;
  int err_total = 0, n_tests = 0, cs, c;
  always #4 i_clk = ~i_clk;
  src_source_model src_source_model_i (.o_por_n(i_power_on_below_n),
    .o_pin_n(i_external_reset_pin_n), .o_wd(i_watchdog_expired),
    .o_bo(i_brownout_below), .o_scan(i_scan_reset_bit));
  src_system_reset_control #(.TOUT_SHORT_CYC(TS), .TOUT_LONG_CYC(TL))
    src_system_reset_control_i (.*);
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic wait_rel(output int n);
    n = 0;
    while (o_core_reset !== 1'b0 && n < 200)
    begin
      @(posedge i_clk); #1 n++;
    end
    chk(n >= TS && n < 200, "release time");
    chk(o_fetch_vector === 1'b1, "fetch pulse missing");
    @(posedge i_clk); #1 chk(o_port === 8'hA5, "port after release");
  endtask
  // Sources are driven 1 ns after the edge and, except the watchdog, checked 1 ns later to prove the set is async
  task automatic run(input int s, output int n);
    int w;
    @(posedge i_clk); #1 src_source_model_i.drive(s, 1);
    #1 if (s != 2) chk(o_core_reset === 1'b1 && o_port === 8'h00, "async");
    repeat (3) @(posedge i_clk);
    #1 src_source_model_i.drive(s, 0);
    if (s == 2)
    begin
      for (w = 0; w < 8 && o_core_reset !== 1'b1; w++)
      begin
        @(posedge i_clk);
        #1;
      end
      chk(o_core_reset === 1'b1, "watchdog reset");
    end
    wait_rel(n);
  endtask
  task automatic gated;
    i_watchdog_enable = 0;
    i_brownout_enable = 0;
    src_source_model_i.drive(2, 1);
    src_source_model_i.drive(3, 1);
    repeat (10) @(posedge i_clk);
    #1 chk(o_core_reset === 1'b0, "disabled source reset");
    src_source_model_i.drive(2, 0);
    src_source_model_i.drive(3, 0);
    @(posedge i_clk); #1 {i_watchdog_enable, i_brownout_enable} = 2'h3;
  endtask
  task automatic print_verdict;
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge i_clk);
    #1 i_rst = 0;
    src_source_model_i.drive(0, 0);
    wait_rel(c);
    for (int s = 0; s < 5; s++) run(s, cs);
    gated();
    i_clock_source_fuse = 2'h3;
    run(4, c);
    chk(c - cs == TL - TS, "long time-out");
    {i_clock_source_fuse, i_startup_time_fuse} = 4'h3;
    run(4, c);
    chk(c - cs == TL - TS, "long time-out");
    print_verdict();
  end
  initial
  begin
    #20000 err_total++;
    print_verdict();
  end
endmodule  // src_system_reset_control_tb
`default_nettype wire
